// file: dv/cfel_pipe_model.sv
// Pipeline, protection unit and bus side model: one-cycle fault cause pulses.
// Assumes the bench raises go_i for one cycle per fault, index 0..18.
`timescale 1ns/100ps
module cfel_pipe_model
    import cfel_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        go_i,
    input  wire logic [4:0]  idx_i,
    input  wire logic [31:0] addr_i,
    output cfel_cause_t      cause_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause_o <= '0;
        end else if (go_i) begin
            cause_o <= {19'h0_0001 << (5'h12 - idx_i), addr_i};
        end else begin
            cause_o <= {19'h0_0000, ~cause_o.addr};
        end
    end
endmodule

// file: dv/core_fault_escalation_lockup_test.sv
// Self-checking bench of the fault escalation and lockup unit.
// Assumes a 20 MHz core clock and the register map of cfel_pkg.
`timescale 1ns/100ps
module core_fault_escalation_lockup_test;
    import cfel_pkg::*;
    logic              clk_i       = 1'b0;
    logic              rst_i       = 1'b1;
    logic [ADDR_W-1:0] reg_addr_i  = '0;
    logic [31:0]       reg_wdata_i = '0;
    logic              reg_wr_i    = 1'b0;
    logic              reg_rd_i    = 1'b0;
    logic [31:0]       reg_rdata_o;
    cfel_cause_t       cause_i;
    cfel_ctx_t         ctx_i       = '0;
    logic              nmi_i       = 1'b0;
    logic              dbg_halt_i  = 1'b0;
    cfel_target_t      handler_req_o;
    logic              lockup_o;
    logic [2:0]        pending_o;
    logic              go          = 1'b0;
    logic [4:0]        idx         = '0;
    logic [31:0]       addr        = '0;
    logic [31:0]       e_fs        = '0;
    logic [31:0]       e_hs        = '0;
    logic [31:0]       e_mma       = '0;
    logic [31:0]       e_bfa       = '0;
    logic [2:0]        e_en        = 3'h7;
    logic [23:0]       e_pr        = 24'h30_2010;
    logic              e_lock      = 1'b0;
    cfel_target_t      e_tgt;
    integer            n_errors    = 0;
    integer            num_checks  = 0;
    integer            seed        = 32'h7b71;
    integer            cyc         = 0;
    int fbit [19] = '{1, 8, 9, 10, 12, 11, 13, 0, 0, 1, 4, 3, 5, 19, 16, 17, 18, 24, 25};
    int fcls [19] = '{3, 1, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0, 0, 2, 2, 2, 2, 2, 2};

    cfel_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .cause_i(cause_i), .ctx_i(ctx_i), .nmi_i(nmi_i),
        .dbg_halt_i(dbg_halt_i), .handler_req_o(handler_req_o), .lockup_o(lockup_o),
        .pending_o(pending_o));
    cfel_pipe_model i_pipe (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .idx_i(idx),
        .addr_i(addr), .cause_o(cause_i));

    always #25 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("Checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask

    // Model the fault, raise it, then compare outputs and status and clear flags
    task automatic fire(input int i);
        int          c;
        int          p;
        logic        esc;
        logic [31:0] a;
        @(posedge clk_i);
        c   = fcls[i];
        p   = (c < 3) ? int'(e_pr[c*8 +: 8]) : 0;
        esc = (c < 3) && (!e_en[c] || ctx_i.kind == cfel_kind_t'(c + 3)
              || ctx_i.exec_prio <= p) && !(i == 4 && ctx_i.bus_entry);
        a     = $random(seed);
        e_tgt = TGT_NONE;
        if (!e_lock) begin
            if (c < 3) e_fs[fbit[i]] = 1'b1;
            if (c == 3) e_hs[1] = 1'b1;
            if (esc) e_hs[30] = 1'b1;
            if (i == 2) begin
                e_fs[15] = 1'b1;
                e_bfa    = a;
            end
            if (i == 9) begin
                e_fs[7] = 1'b1;
                e_mma   = a;
            end
            if ((c == 3 || esc) && ctx_i.kind inside {EK_NMI, EK_HARD}) e_lock = 1'b1;
            else if (c == 3 || esc) e_tgt = TGT_HARD;
            else if (!(ctx_i.mask_on && p >= ctx_i.mask_prio)) e_tgt = cfel_target_t'(c + 1);
        end
        go   <= 1'b1;
        idx  <= 5'(i);
        addr <= a;
        @(posedge clk_i);
        go   <= 1'b0;
        @(posedge clk_i);
        #1 chk(32'(handler_req_o), 32'(e_tgt));
        chk(32'(lockup_o), 32'(e_lock));
        rdc(OFS_FAULT_STAT, e_fs);
        rdc(OFS_HARD_STAT, e_hs);
        rdc(OFS_MM_ADDR, e_mma);
        rdc(OFS_BUS_ADDR, e_bfa);
        wr(OFS_FAULT_STAT, 32'hFFFF_FFFF);
        wr(OFS_HARD_STAT, 32'hFFFF_FFFF);
        e_fs = '0;
        e_hs = '0;
    endtask

    task automatic pulse(input bit dbg, input logic exp);
        @(posedge clk_i);
        nmi_i      <= !dbg;
        dbg_halt_i <= dbg;
        @(posedge clk_i);
        nmi_i      <= 1'b0;
        dbg_halt_i <= 1'b0;
        #1 chk(32'(lockup_o), 32'(exp));
        e_lock = exp;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 32; a += 4) rdc(8'(a), 32'h0000_0000);
        wr(OFS_HANDLER_EN, 32'h0000_0007);
        wr(OFS_PRIO, 32'(e_pr));
        rdc(OFS_PRIO, 32'(e_pr));
        for (int s = 0; s < 4; s++) begin
            e_en = (s == 1) ? 3'h0 : 3'h7;
            wr(OFS_HANDLER_EN, 32'(e_en));
            for (int i = 0; i < 19; i++) begin
                ctx_i.kind      <= (s == 2 && fcls[i] < 3) ? cfel_kind_t'(fcls[i] + 3) :
                                   (s == 3) ? EK_OTHER : EK_THREAD;
                ctx_i.exec_prio <= (s == 3) ? 8'h20 : 8'hFF;
                fire(i);
            end
        end
        ctx_i.kind      <= EK_BUS;
        ctx_i.bus_entry <= 1'b1;
        fire(4);
        ctx_i.kind      <= EK_THREAD;
        ctx_i.bus_entry <= 1'b0;
        ctx_i.exec_prio <= 8'hFF;
        ctx_i.mask_on   <= 1'b1;
        ctx_i.mask_prio <= 8'h30;
        fire(18);
        chk(32'(pending_o), 32'h0000_0004);
        @(posedge clk_i);
        ctx_i.mask_on <= 1'b0;
        @(posedge clk_i);
        #1 chk(32'(handler_req_o), 32'(TGT_USAGE));
        wr(OFS_FAULT_STAT, 32'hFFFF_FFFF);
        ctx_i.kind <= EK_HARD;
        fire(0);
        rdc(OFS_CORE_STATE, 32'h0000_0001);
        fire(18);
        pulse(1'b0, 1'b0);
        ctx_i.kind <= EK_NMI;
        fire(0);
        rdc(OFS_CORE_STATE, 32'h0000_0005);
        pulse(1'b0, 1'b1);
        pulse(1'b1, 1'b0);
        end_sim();
    end
endmodule

// file: logic/cfel_classify.sv
// Sorts raw fault causes into status flags and fault classes.
// Assumes cause bits are one-cycle pulses from the pipeline on the core clock.
`timescale 1ns/100ps
module cfel_classify
    import cfel_pkg::*;
#(
    parameter bit HAS_FPU = 1'b1
) (
    input  wire cfel_cause_t  cause_i,
    output logic [31:0]       set_bits_o,
    output logic [2:0]        class_hit_o,
    output logic              mm_cap_o,
    output logic              bus_cap_o
);
    wire fp_mem = HAS_FPU & cause_i.mpu_lsp;
    wire fp_bus = HAS_FPU & cause_i.lsp_bus;
    wire iacc   = cause_i.mpu_iviol | cause_i.never_exec;

    assign mm_cap_o  = cause_i.mpu_dviol;
    assign bus_cap_o = cause_i.dbus_exact;

    always_comb begin
        set_bits_o = RST_WORD;
        set_bits_o[B_INSTR_ACCESS_VIOL]  = iacc;
        set_bits_o[B_DATA_ACCESS_VIOL]   = cause_i.mpu_dviol;
        set_bits_o[B_MEM_UNSTACKING_ERR] = cause_i.mpu_unstk;
        set_bits_o[B_MEM_STACKING_ERR]   = cause_i.mpu_stk;
        set_bits_o[B_MEM_LAZY_FP_ERR]    = fp_mem;
        set_bits_o[B_MM_ADDR_VALID]      = mm_cap_o;
        set_bits_o[B_PREFETCH_BUS_ERR]   = cause_i.ibus_err;
        set_bits_o[B_EXACT_DATA_BUS_ERR] = cause_i.dbus_exact;
        set_bits_o[B_INEXACT_DATA_BUS]   = cause_i.dbus_inexact;
        set_bits_o[B_BUS_UNSTACKING_ERR] = cause_i.unstk_bus;
        set_bits_o[B_BUS_STACKING_ERR]   = cause_i.stk_bus;
        set_bits_o[B_BUS_LAZY_FP_ERR]    = fp_bus;
        set_bits_o[B_BUS_ADDR_VALID]     = bus_cap_o;
        set_bits_o[B_UNDEFINED_OPCODE]   = cause_i.undef;
        set_bits_o[B_BAD_ISA_STATE]      = cause_i.bad_isa;
        set_bits_o[B_BAD_RETURN_VALUE]   = cause_i.bad_ret;
        set_bits_o[B_COPROC_ACCESS]      = cause_i.coproc;
        set_bits_o[B_MISALIGNED_ACCESS]  = cause_i.misaligned;
        set_bits_o[B_ZERO_DIVISOR]       = cause_i.zero_div;
        class_hit_o[C_MEM]   = |set_bits_o[6:0];
        class_hit_o[C_BUS]   = |set_bits_o[14:8];
        class_hit_o[C_USAGE] = |set_bits_o[31:16];
    end

endmodule

// file: logic/cfel_core.sv
// Fault status, escalation to hard fault and lockup control of the core.
// Assumes pipeline, protection unit and debug logic share clk_i.
`timescale 1ns/100ps
// Behaviour
// - Bus errors on fetch, vector read or data access raise a fault.
// - Executing from a never-execute region raises a fault.
// - Privilege breaks or uncovered regions raise a memory protection fault.
// - Vector read bus error goes to hard fault and sets its flag.
// - Each escalation to hard fault sets the escalated flag.
// - Protection mismatches go to memory handler with per-cause flags.
// - Bus errors go to bus handler with per-cause flags.
// - Usage handler takes six cases, each with its own flag.
// - Never-execute fetch flags instruction violation even without protection unit.
// - Lazy floating-point flags exist only when the FPU is present.
// - Configurable faults have programmable priority and a handler enable.
// - Same-kind fault inside its own handler escalates to hard fault.
// - Fault not above current execution priority escalates to hard fault.
// - Fault with disabled handler escalates to hard fault.
// - Bus error stacking into bus handler does not escalate.
// - Only reset and NMI preempt hard fault; it preempts all else.
// - Exact data bus errors and data access violations capture the faulting address.
// - Hard fault inside NMI or hard fault handler enters lockup.
// - Lockup lasts until reset, NMI or debugger halt.
// - Lockup entered from NMI is not released by a later NMI.
// - A fault not above the mask limit stays pending.
module cfel_core
    import cfel_pkg::*;
#(
    parameter bit HAS_FPU = 1'b1
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [31:0]       reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic [31:0]            reg_rdata_o,
    input  wire cfel_cause_t       cause_i,
    input  wire cfel_ctx_t         ctx_i,
    input  wire logic              nmi_i,
    input  wire logic              dbg_halt_i,
    output cfel_target_t           handler_req_o,
    output logic                   lockup_o,
    output logic [2:0]             pending_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    if (HAS_FPU !== 1'b0 && HAS_FPU !== 1'b1) begin : g_bad_fpu
        $error("HAS_FPU must be 0 or 1");
    end

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef enum logic {LK_RUN, LK_LOCKED} cfel_lock_t;

    logic [31:0]    fault_status;
    logic [31:0]    hard_status;
    logic [31:0]    mm_addr;
    logic [31:0]    bus_addr;
    logic [2:0]     handler_en;
    logic [23:0]    prio_cfg;
    logic [2:0]     pend;
    logic           lock_from_nmi;
    cfel_lock_t     lock_state;
    cfel_target_t   target;
    logic [31:0]    rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Classification
    logic [31:0]    set_bits;
    logic [2:0]     class_hit;
    logic           mm_cap;
    logic           bus_cap;

    cfel_classify #(.HAS_FPU(HAS_FPU)) u_classify (
        .cause_i     (cause_i),
        .set_bits_o  (set_bits),
        .class_hit_o (class_hit),
        .mm_cap_o    (mm_cap),
        .bus_cap_o   (bus_cap)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Escalation per configurable class
    wire            locked    = (lock_state == LK_LOCKED);
    wire [2:0]      req       = (class_hit | pend) & {3{!locked}};
    wire            bus_exempt = cause_i.stk_bus & ctx_i.bus_entry;
    logic [2:0]     take;
    logic [2:0]     esc;

    function automatic cfel_kind_t class_kind(input int c);
        case (c)
            C_MEM:   class_kind = EK_MEM;
            C_BUS:   class_kind = EK_BUS;
            default: class_kind = EK_USAGE;
        endcase
    endfunction

    for (genvar c = 0; c < 3; c++) begin : g_class
        cfel_escalate u_esc (
            .req_i      (req[c]),
            .own_kind_i (class_kind(c)),
            .prio_i     (prio_cfg[c*PRIO_W +: PRIO_W]),
            .enable_i   (handler_en[c]),
            .exempt_i   ((c == C_BUS) & bus_exempt),
            .ctx_i      (ctx_i),
            .take_o     (take[c]),
            .escalate_o (esc[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outcome selection
    wire vec_err    = cause_i.vec_bus_err & !locked;
    wire any_esc    = |esc;
    wire hard_req   = vec_err | any_esc;
    wire fixed_busy = (ctx_i.kind == EK_NMI) | (ctx_i.kind == EK_HARD);
    wire go_lock    = hard_req & fixed_busy;
    wire go_hard    = hard_req & !fixed_busy;
    wire [2:0] pick = take[C_BUS] ? 3'b010 :
                      take[C_MEM] ? 3'b001 :
                      take[C_USAGE] ? 3'b100 : 3'b000;
    wire [2:0] next_pend = hard_req ? (req & ~esc) :
                           (req & ~pick);

    cfel_target_t next_target;
    // Any hard fault request wins; own handlers wait in pending meanwhile
    assign next_target = go_hard     ? TGT_HARD :
                         hard_req    ? TGT_NONE :
                         pick[C_BUS] ? TGT_BUS :
                         pick[C_MEM] ? TGT_MEM :
                         pick[C_USAGE] ? TGT_USAGE : TGT_NONE;

    ////////////////////////////////////////////////////////////////////////////
    // Lockup control
    wire release_lock = dbg_halt_i | (nmi_i & !lock_from_nmi);
    cfel_lock_t next_lock;
    always_comb begin
        case (lock_state)
            LK_RUN:    next_lock = go_lock ? LK_LOCKED : LK_RUN;
            LK_LOCKED: next_lock = release_lock ? LK_RUN : LK_LOCKED;
            default:   next_lock = LK_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_state    <= LK_RUN;
            lock_from_nmi <= 1'b0;
        end else begin
            lock_state <= next_lock;
            if (lock_state == LK_RUN && go_lock) begin
                lock_from_nmi <= (ctx_i.kind == EK_NMI);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register decode
    wire hit_fs   = (reg_addr_i == OFS_FAULT_STAT);
    wire hit_hs   = (reg_addr_i == OFS_HARD_STAT);
    wire hit_en   = (reg_addr_i == OFS_HANDLER_EN);
    wire hit_prio = (reg_addr_i == OFS_PRIO);
    wire [31:0] clr_fs = (reg_wr_i & hit_fs) ? reg_wdata_i : RST_WORD;
    wire [31:0] clr_hs = (reg_wr_i & hit_hs) ? reg_wdata_i : RST_WORD;
    wire [31:0] set_fs = locked ? RST_WORD : set_bits;
    wire [31:0] set_hs = {1'b0, any_esc, 28'h000_0000, vec_err, 1'b0};
    wire [31:0] next_fs = (fault_status & ~clr_fs) | set_fs;
    wire [31:0] next_hs = (hard_status & ~clr_hs) | set_hs;
    wire [31:0] core_word = {26'h000_0000, pend, lock_from_nmi, 1'b0, locked};

    always_comb begin
        case (reg_addr_i)
            OFS_FAULT_STAT: rdata = fault_status;
            OFS_HARD_STAT:  rdata = hard_status;
            OFS_MM_ADDR:    rdata = mm_addr;
            OFS_BUS_ADDR:   rdata = bus_addr;
            OFS_HANDLER_EN: rdata = {29'h0000_0000, handler_en};
            OFS_PRIO:       rdata = {8'h00, prio_cfg};
            OFS_CORE_STATE: rdata = core_word;
            default:        rdata = RST_WORD;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_status <= RST_WORD;
            hard_status  <= RST_WORD;
            handler_en   <= RST_HANDLER_EN;
            prio_cfg     <= RST_PRIO;
            reg_rdata_o  <= RST_WORD;
        end else begin
            fault_status <= next_fs;
            hard_status  <= next_hs;
            if (reg_wr_i && hit_en) begin
                handler_en <= reg_wdata_i[2:0];
            end
            if (reg_wr_i && hit_prio) begin
                prio_cfg <= reg_wdata_i[23:0];
            end
            reg_rdata_o <= reg_rd_i ? rdata : RST_WORD;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mm_addr  <= RST_WORD;
            bus_addr <= RST_WORD;
            pend     <= 3'h0;
            target   <= TGT_NONE;
        end else begin
            if (mm_cap && !locked) begin
                mm_addr <= cause_i.addr;
            end
            if (bus_cap && !locked) begin
                bus_addr <= cause_i.addr;
            end
            pend   <= next_pend;
            target <= next_target;
        end
    end

    assign handler_req_o = target;
    assign lockup_o      = locked;
    assign pending_o     = pend;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_vector_hard:
        assert property (vec_err && !fixed_busy |=> target == TGT_HARD
                         && hard_status[B_VECTOR_READ_ERR])
        else $error("vector read error did not reach hard fault");
    a_escalated_flag:
        assert property (any_esc && !locked |=> hard_status[B_ESCALATED])
        else $error("escalation flag not set");
    a_disabled_handler:
        assert property (req[C_USAGE] && !handler_en[C_USAGE] && !fixed_busy
                         |=> target == TGT_HARD)
        else $error("disabled handler fault not escalated");
    a_stack_exempt:
        assert property (bus_exempt && !locked && !vec_err && esc == 3'b000
                         |=> target == TGT_BUS)
        else $error("bus stacking error on bus entry escalated");
    a_lockup_entry:
        assert property (!locked && hard_req && fixed_busy |=> lockup_o
                         && target == TGT_NONE)
        else $error("hard fault in fixed handler did not lock up");
    a_lockup_hold:
        assert property (locked && !nmi_i && !dbg_halt_i |=> locked)
        else $error("lockup left without release");
    a_nmi_no_release:
        assert property (locked && lock_from_nmi && !dbg_halt_i |=> locked)
        else $error("nmi released lockup entered from nmi");
    a_halt_release:
        assert property (locked && dbg_halt_i |=> !locked)
        else $error("debug halt did not release lockup");
    a_bus_address:
        assert property (bus_cap && !locked |=> bus_addr == $past(cause_i.addr)
                         && fault_status[B_BUS_ADDR_VALID])
        else $error("bus fault address not captured");
    a_never_exec_flag:
        assert property (cause_i.never_exec && !locked
                         |=> fault_status[B_INSTR_ACCESS_VIOL])
        else $error("never-execute fetch not flagged");
    a_flag_sticky:
        assert property (fault_status[B_ZERO_DIVISOR] && !(reg_wr_i && hit_fs)
                         |=> fault_status[B_ZERO_DIVISOR])
        else $error("cause flag dropped without clear");
    a_masked_pends:
        assert property (class_hit[C_MEM] && !locked && !hard_req && !take[C_MEM]
                         |=> pend[C_MEM] && target != TGT_MEM)
        else $error("masked fault not held pending");
    a_hard_target:
        assert property (go_hard |=> target == TGT_HARD)
        else $error("hard fault request not taken");
    a_hard_alone:
        assert property (hard_req |=> target == TGT_HARD || target == TGT_NONE)
        else $error("own handler chosen beside a hard fault");
    a_mem_address:
        assert property (mm_cap && !locked |=> mm_addr == $past(cause_i.addr)
                         && fault_status[B_MM_ADDR_VALID])
        else $error("memory fault address not captured");
    a_nmi_release:
        assert property (locked && nmi_i && !lock_from_nmi |=> !locked)
        else $error("nmi did not release lockup");
    a_locked_quiet:
        assert property (locked |=> target == TGT_NONE && $stable(mm_addr)
                         && $stable(bus_addr))
        else $error("fault handled while locked");
    a_zero_div_flag:
        assert property (cause_i.zero_div && !locked |=> fault_status[B_ZERO_DIVISOR])
        else $error("divide by zero not flagged");

    c_lockup: cover property (!locked ##1 locked);
    c_hard_taken: cover property (target == TGT_HARD);
    c_mem_taken: cover property (target == TGT_MEM);
    c_pend_then_take: cover property (pend[C_BUS] ##[1:20] target == TGT_BUS);

endmodule

// file: logic/cfel_escalate.sv
// Decides for one configurable fault class: own handler, hard fault, or wait.
// Assumes lower priority number means higher urgency.
`timescale 1ns/100ps
module cfel_escalate
    import cfel_pkg::*;
(
    input  wire logic              req_i,
    input  wire cfel_kind_t        own_kind_i,
    input  wire logic [PRIO_W-1:0] prio_i,
    input  wire logic              enable_i,
    input  wire logic              exempt_i,
    input  wire cfel_ctx_t         ctx_i,
    output logic                   take_o,
    output logic                   escalate_o
);
    wire fixed_busy = (ctx_i.kind == EK_NMI) | (ctx_i.kind == EK_HARD);
    wire same_kind  = (ctx_i.kind == own_kind_i);
    wire beats_exec = (ctx_i.kind == EK_THREAD) |
                      (!fixed_busy & (prio_i < ctx_i.exec_prio));
    wire beats_mask = !ctx_i.mask_on | (prio_i < ctx_i.mask_prio);

    assign escalate_o = req_i & !exempt_i &
                        (!enable_i | same_kind | !beats_exec);
    assign take_o     = req_i & (exempt_i | (!escalate_o & beats_mask));

endmodule

// file: logic/cfel_pkg.sv
// Shared constants and types of the core fault escalation and lockup unit.
// Assumes one core clock; all fault sources arrive from logic on that clock.
package cfel_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam int          ADDR_W         = 8;
    localparam int          PRIO_W         = 8;
    localparam logic [7:0]  OFS_FAULT_STAT = 8'h00;
    localparam logic [7:0]  OFS_HARD_STAT  = 8'h04;
    localparam logic [7:0]  OFS_MM_ADDR    = 8'h08;
    localparam logic [7:0]  OFS_BUS_ADDR   = 8'h0C;
    localparam logic [7:0]  OFS_HANDLER_EN = 8'h10;
    localparam logic [7:0]  OFS_PRIO       = 8'h14;
    localparam logic [7:0]  OFS_CORE_STATE = 8'h18;

    ////////////////////////////////////////////////////////////////////////////
    // Flag positions in fault status (mem bits 7:0, bus 15:8, usage 31:16), last two in hard status
    localparam int B_INSTR_ACCESS_VIOL  = 0;
    localparam int B_DATA_ACCESS_VIOL   = 1;
    localparam int B_MEM_UNSTACKING_ERR = 3;
    localparam int B_MEM_STACKING_ERR   = 4;
    localparam int B_MEM_LAZY_FP_ERR    = 5;
    localparam int B_MM_ADDR_VALID      = 7;
    localparam int B_PREFETCH_BUS_ERR   = 8;
    localparam int B_EXACT_DATA_BUS_ERR = 9;
    localparam int B_INEXACT_DATA_BUS   = 10;
    localparam int B_BUS_UNSTACKING_ERR = 11;
    localparam int B_BUS_STACKING_ERR   = 12;
    localparam int B_BUS_LAZY_FP_ERR    = 13;
    localparam int B_BUS_ADDR_VALID     = 15;
    localparam int B_UNDEFINED_OPCODE   = 16;
    localparam int B_BAD_ISA_STATE      = 17;
    localparam int B_BAD_RETURN_VALUE   = 18;
    localparam int B_COPROC_ACCESS      = 19;
    localparam int B_MISALIGNED_ACCESS  = 24;
    localparam int B_ZERO_DIVISOR       = 25;
    localparam int B_VECTOR_READ_ERR    = 1;
    localparam int B_ESCALATED          = 30;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [31:0] RST_WORD       = 32'h0000_0000;
    localparam logic [2:0]  RST_HANDLER_EN = 3'h0;
    localparam logic [23:0] RST_PRIO       = 24'h00_0000;

    // Configurable fault classes, also index into enables and priorities
    localparam int C_MEM   = 0;
    localparam int C_BUS   = 1;
    localparam int C_USAGE = 2;

    typedef enum logic [2:0] {
        EK_THREAD, EK_NMI, EK_HARD, EK_MEM, EK_BUS, EK_USAGE, EK_OTHER
    } cfel_kind_t;

    typedef enum logic [2:0] {
        TGT_NONE, TGT_MEM, TGT_BUS, TGT_USAGE, TGT_HARD
    } cfel_target_t;

    typedef struct packed {
        logic        vec_bus_err;
        logic        ibus_err;
        logic        dbus_exact;
        logic        dbus_inexact;
        logic        stk_bus;
        logic        unstk_bus;
        logic        lsp_bus;
        logic        never_exec;
        logic        mpu_iviol;
        logic        mpu_dviol;
        logic        mpu_stk;
        logic        mpu_unstk;
        logic        mpu_lsp;
        logic        coproc;
        logic        undef;
        logic        bad_isa;
        logic        bad_ret;
        logic        misaligned;
        logic        zero_div;
        logic [31:0] addr;
    } cfel_cause_t;

    typedef struct packed {
        cfel_kind_t          kind;
        logic [PRIO_W-1:0]   exec_prio;
        logic                mask_on;
        logic [PRIO_W-1:0]   mask_prio;
        logic                bus_entry;
    } cfel_ctx_t;

endpackage
